/* File: rtl/lpac_defines.vh */
// Overview of operation
// - view holds partner base page abilities
// - after completion, next page replaces view
// - bit 15 partner next page request
// - bit 14 acknowledge follows received bursts
// - bit 13 partner remote fault flag
// - bit 12 reserved, reads zero while the base page is shown
// - bit 11 partner asymmetric pause ability
// - bit 10 partner symmetric pause ability
// - bit 9 partner four pair ability
// - bit 8 fast full duplex ability
// - bit 7 fast half duplex ability
// - bit 6 slow full duplex ability
// - bit 5 slow half duplex ability
// - bits 4:0 selector, zero after reset
// - selector 00001 means ieee 802.3
`ifndef LPAC_DEFINES_VH
`define LPAC_DEFINES_VH
// register word indexes, byte address is index times four
`define LPAC_IDX_W 6
`define LPAC_IDX_VIEW 6'h05
`define LPAC_IDX_NEXT 6'h10
`define LPAC_IDX_CTRL 6'h11
`define LPAC_IDX_STAT 6'h12
`define LPAC_IDX_IRQ_STAT 6'h13
`define LPAC_IDX_IRQ_MASK 6'h14
`define LPAC_ADDR_W 8
`define LPAC_IDX_HI 7
`define LPAC_IDX_LO 2
// page layout
`define LPAC_PAGE_W 16
`define LPAC_BIT_NP 15
`define LPAC_BIT_ACK 14
`define LPAC_BIT_RF 13
`define LPAC_BIT_RSV 12
`define LPAC_BIT_ASM 11
`define LPAC_BIT_PAUSE 10
`define LPAC_BIT_T4 9
`define LPAC_BIT_TXFD 8
`define LPAC_BIT_TX 7
`define LPAC_BIT_TFD 6
`define LPAC_BIT_T10 5
`define LPAC_SEL_HI 4
`define LPAC_SEL_LO 0
`define LPAC_SEL_W 5
`define LPAC_SEL_IEEE 5'h01
`define LPAC_PAGE_RST 16'h0000
`define LPAC_SEL_RST 5'h00
// control, status and interrupt layouts
`define LPAC_CTRL_W 1
`define LPAC_CTRL_NPEN 0
`define LPAC_CTRL_RST 1'h0
`define LPAC_STAT_W 4
`define LPAC_STAT_DONE 0
`define LPAC_STAT_IEEE 1
`define LPAC_STAT_NEXT 2
`define LPAC_STAT_BASE 3
`define LPAC_IRQ_W 4
`define LPAC_IRQ_BASE 0
`define LPAC_IRQ_NEXT 1
`define LPAC_IRQ_RF 2
`define LPAC_IRQ_DONE 3
`define LPAC_IRQ_RST 4'h0
`define LPAC_DATA_W 32
`define LPAC_DATA_RST 32'h00000000
`endif

/* File: rtl/lpac_irq.v */
`timescale 1ns/1ps
`include "lpac_defines.vh"
module lpac_irq (
	input wire pclk, // bus clock
	input wire presetn, // async reset, active low
	input wire clk_en, // freezes state while low
	input wire [`LPAC_IRQ_W-1:0] event_pulse, // one-cycle events
	input wire [`LPAC_IRQ_W-1:0] clear_ones, // write-one-to-clear mask
	input wire mask_we, // mask write strobe
	input wire [`LPAC_IRQ_W-1:0] mask_wdata, // new mask value
	output wire [`LPAC_IRQ_W-1:0] irq_status, // sticky status bits
	output reg [`LPAC_IRQ_W-1:0] irq_mask, // enable mask
	output wire irq // level interrupt
);
	reg [`LPAC_IRQ_W-1:0] sticky;
	genvar i;

	// sticky bits per event; a set in the clearing cycle wins
	generate
		for (i = 0; i < `LPAC_IRQ_W; i = i + 1) begin : g_bit
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sticky[i] <= 1'b0;
				end else if (clk_en) begin
					if (event_pulse[i]) begin
						sticky[i] <= 1'b1;
					end else if (clear_ones[i]) begin
						sticky[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// mask register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= `LPAC_IRQ_RST;
		end else if (clk_en && mask_we) begin
			irq_mask <= mask_wdata;
		end
	end

	assign irq_status = sticky;
	assign irq = |(sticky & irq_mask);
endmodule

/* File: rtl/lpac_top.v */
`timescale 1ns/1ps
`include "lpac_defines.vh"
module lpac_top (
	input wire pclk, // bus and management clock
	input wire presetn, // async reset, active low
	input wire clk_en, // freezes all state while low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [`LPAC_ADDR_W-1:0] paddr, // apb byte address
	input wire [`LPAC_DATA_W-1:0] pwdata, // apb write data
	output reg [`LPAC_DATA_W-1:0] prdata, // apb read data
	output wire pready, // apb ready
	output reg pslverr, // apb error on unmapped address
	input wire [`LPAC_PAGE_W-1:0] rx_page, // page word from negotiation engine
	input wire rx_base_valid, // pulse: rx_page is a base page
	input wire rx_next_valid, // pulse: rx_page is a next page
	input wire rx_ack, // acknowledge level from received bursts
	input wire an_complete, // negotiation completed successfully
	input wire an_restart, // pulse: negotiation restarts
	output wire irq // level interrupt
);
	reg [`LPAC_PAGE_W-1:0] base_page;
	reg [`LPAC_PAGE_W-1:0] next_page;
	reg partner_ack;
	reg base_seen;
	reg next_seen;
	reg an_done;
	reg ctrl_np_enable;
	reg rf_prev;
	reg [`LPAC_PAGE_W-1:0] partner_ability_view;
	reg [`LPAC_PAGE_W-1:0] next_base_page;
	reg [`LPAC_DATA_W-1:0] next_prdata;
	reg next_pslverr;
	wire [`LPAC_IDX_W-1:0] idx;
	wire setup;
	wire access;
	wire wr_access;
	wire show_next;
	wire sel_ieee;
	wire [`LPAC_STAT_W-1:0] status_word;
	wire [`LPAC_IRQ_W-1:0] irq_events;
	wire [`LPAC_IRQ_W-1:0] irq_clear;
	wire [`LPAC_IRQ_W-1:0] irq_status;
	wire [`LPAC_IRQ_W-1:0] irq_mask;
	wire mask_we;
	wire ctrl_we;

	// apb phase decode
	assign idx = paddr[`LPAC_IDX_HI:`LPAC_IDX_LO];
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_access = access & pwrite & clk_en;
	assign pready = clk_en;

	// write strobes; the view and the next page word take no write
	assign ctrl_we = wr_access & (idx == `LPAC_IDX_CTRL);
	assign mask_we = wr_access & (idx == `LPAC_IDX_IRQ_MASK);
	assign irq_clear = (wr_access && idx == `LPAC_IDX_IRQ_STAT) ?
		pwdata[`LPAC_IRQ_W-1:0] : `LPAC_IRQ_RST;

	// control register: next page support enable
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_np_enable <= `LPAC_CTRL_RST;
		end else if (ctrl_we) begin
			ctrl_np_enable <= pwdata[`LPAC_CTRL_NPEN];
		end
	end

	// build the stored base page from the received word field by field
	always @* begin
		next_base_page = `LPAC_PAGE_RST;
		next_base_page[`LPAC_BIT_NP] = rx_page[`LPAC_BIT_NP];
		next_base_page[`LPAC_BIT_RF] = rx_page[`LPAC_BIT_RF];
		next_base_page[`LPAC_BIT_RSV] = 1'b0;
		next_base_page[`LPAC_BIT_ASM] = rx_page[`LPAC_BIT_ASM];
		next_base_page[`LPAC_BIT_PAUSE] = rx_page[`LPAC_BIT_PAUSE];
		next_base_page[`LPAC_BIT_T4] = rx_page[`LPAC_BIT_T4];
		next_base_page[`LPAC_BIT_TXFD] = rx_page[`LPAC_BIT_TXFD];
		next_base_page[`LPAC_BIT_TX] = rx_page[`LPAC_BIT_TX];
		next_base_page[`LPAC_BIT_TFD] = rx_page[`LPAC_BIT_TFD];
		next_base_page[`LPAC_BIT_T10] = rx_page[`LPAC_BIT_T10];
		next_base_page[`LPAC_SEL_HI:`LPAC_SEL_LO] =
			rx_page[`LPAC_SEL_HI:`LPAC_SEL_LO];
	end

	// base page capture; a restart keeps the old abilities until a new page
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_page <= `LPAC_PAGE_RST;
			base_seen <= 1'b0;
		end else if (clk_en) begin
			if (rx_base_valid) begin
				base_page <= next_base_page;
				base_seen <= 1'b1;
			end
		end
	end

	// next page capture; cleared on restart so the base page shows again
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			next_page <= `LPAC_PAGE_RST;
			next_seen <= 1'b0;
		end else if (clk_en) begin
			if (rx_next_valid) begin
				next_page <= rx_page;
				next_seen <= 1'b1;
			end else if (an_restart) begin
				next_page <= `LPAC_PAGE_RST;
				next_seen <= 1'b0;
			end
		end
	end

	// acknowledge follows the burst engine only; no bus path reaches it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			partner_ack <= 1'b0;
		end else if (clk_en) begin
			partner_ack <= rx_ack;
		end
	end

	// completion flag, dropped by a restart
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			an_done <= 1'b0;
		end else if (clk_en) begin
			if (an_restart) begin
				an_done <= 1'b0;
			end else if (an_complete) begin
				an_done <= 1'b1;
			end
		end
	end

	// view selection: next page only after success with next pages enabled
	assign show_next = ctrl_np_enable & an_done & next_seen;

	always @* begin
		if (show_next) begin
			partner_ability_view = next_page;
		end else begin
			partner_ability_view = base_page;
		end
		partner_ability_view[`LPAC_BIT_ACK] = partner_ack;
		if (!show_next) begin
			partner_ability_view[`LPAC_BIT_RSV] = 1'b0;
		end
	end

	// selector check against the ieee 802.3 code
	assign sel_ieee = base_seen &&
		(base_page[`LPAC_SEL_HI:`LPAC_SEL_LO] == `LPAC_SEL_IEEE);

	// status word
	assign status_word[`LPAC_STAT_DONE] = an_done;
	assign status_word[`LPAC_STAT_IEEE] = sel_ieee;
	assign status_word[`LPAC_STAT_NEXT] = show_next;
	assign status_word[`LPAC_STAT_BASE] = base_seen;

	// remote fault edge tracking for its interrupt
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rf_prev <= 1'b0;
		end else if (clk_en) begin
			rf_prev <= base_page[`LPAC_BIT_RF];
		end
	end

	// interrupt events
	assign irq_events[`LPAC_IRQ_BASE] = rx_base_valid;
	assign irq_events[`LPAC_IRQ_NEXT] = rx_next_valid;
	assign irq_events[`LPAC_IRQ_RF] = base_page[`LPAC_BIT_RF] & ~rf_prev;
	assign irq_events[`LPAC_IRQ_DONE] = an_complete & ~an_done & ~an_restart;

	lpac_irq i_lpac_irq (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.event_pulse(irq_events),
		.clear_ones(irq_clear),
		.mask_we(mask_we),
		.mask_wdata(pwdata[`LPAC_IRQ_W-1:0]),
		.irq_status(irq_status),
		.irq_mask(irq_mask),
		.irq(irq)
	);

	// read mux and error decode, evaluated in the setup cycle
	always @* begin
		next_prdata = `LPAC_DATA_RST;
		next_pslverr = 1'b0;
		if (idx == `LPAC_IDX_VIEW) begin
			next_prdata[`LPAC_PAGE_W-1:0] = partner_ability_view;
		end else if (idx == `LPAC_IDX_NEXT) begin
			next_prdata[`LPAC_PAGE_W-1:0] = next_page;
		end else if (idx == `LPAC_IDX_CTRL) begin
			next_prdata[`LPAC_CTRL_NPEN] = ctrl_np_enable;
		end else if (idx == `LPAC_IDX_STAT) begin
			next_prdata[`LPAC_STAT_W-1:0] = status_word;
		end else if (idx == `LPAC_IDX_IRQ_STAT) begin
			next_prdata[`LPAC_IRQ_W-1:0] = irq_status;
		end else if (idx == `LPAC_IDX_IRQ_MASK) begin
			next_prdata[`LPAC_IRQ_W-1:0] = irq_mask;
		end else begin
			next_pslverr = 1'b1;
		end
		if (pwrite) begin
			next_prdata = `LPAC_DATA_RST;
		end
	end

	// read data and error registered ahead of the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `LPAC_DATA_RST;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			if (setup) begin
				prdata <= next_prdata;
				pslverr <= next_pslverr;
			end else if (access) begin
				prdata <= `LPAC_DATA_RST;
				pslverr <= 1'b0;
			end
		end
	end
endmodule

/* File: verif/lpac_properties.sv */
`timescale 1ns/1ps
module lpac_properties (
	input wire pclk, // clock
	input wire presetn, // reset
	input wire clk_en, // enable
	input wire psel, // select
	input wire penable, // access
	input wire pwrite, // write
	input wire [7:0] paddr, // address
	input wire [31:0] prdata, // read data
	input wire pready, // ready
	input wire pslverr, // error
	input wire rx_ack, // ack level
	input wire rx_base_valid, // base pulse
	input wire irq // interrupt
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// completed transfer and decoded word index
	wire acc = psel && penable && pready;
	wire [5:0] idx = paddr[7:2];
	wire hit = idx == 6'h05 || (idx >= 6'h10 && idx <= 6'h14);
	// completed write, kept as a signal so that $past sees a plain name
	wire wr_done = acc && pwrite;
	property p_upper;
		acc |-> prdata[31:16] == 16'h0000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper half set");
	property p_rsv;
		acc && !pwrite && idx == 6'h05 |-> !prdata[12];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	property p_ack;
		acc && !pwrite && idx == 6'h05 && $past(clk_en) && $past(clk_en, 2)
			|-> prdata[14] == $past(rx_ack, 2);
	endproperty
	a_ack: assert property (p_ack) else $error("ack bit stale");
	property p_err;
		acc && !hit |-> pslverr && prdata == 32'h00000000;
	endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
	property p_noerr;
		acc && hit |-> !pslverr;
	endproperty
	a_noerr: assert property (p_noerr) else $error("mapped refused");
	property p_wzero;
		acc && pwrite |-> prdata == 32'h00000000;
	endproperty
	a_wzero: assert property (p_wzero) else $error("write returns data");
	property p_idle;
		!psel && !$past(psel) && $past(clk_en) |-> prdata == 32'h00000000;
	endproperty
	a_idle: assert property (p_idle) else $error("idle data not zero");
	// interrupt only drops after a register write
	property p_irqfall;
		$fell(irq) |-> $past(wr_done);
	endproperty
	a_irqfall: assert property (p_irqfall) else $error("irq dropped alone");
	c_base: cover property (rx_base_valid ##[2:8] (acc && idx == 6'h05));
	c_err: cover property (acc && pslverr);
	c_irq: cover property ($rose(irq));
endmodule
bind lpac_top lpac_properties i_lpac_properties (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_ack(rx_ack),
	.rx_base_valid(rx_base_valid), .irq(irq));

/* File: verif/lpac_partner.sv */
`timescale 1ns/1ps
module lpac_partner (
	input wire pclk, // clock
	output logic [15:0] rx_page, // page word
	output logic rx_base_valid, // base pulse
	output logic rx_next_valid, // next pulse
	output logic rx_ack, // ack level
	output logic an_complete, // done level
	output logic an_restart // restart pulse
);
	initial begin
		rx_page = 16'h0000;
		rx_base_valid = 1'b0;
		rx_next_valid = 1'b0;
		rx_ack = 1'b0;
		an_complete = 1'b0;
		an_restart = 1'b0;
	end
	// one page, then the word goes stale
	task automatic send(input logic nxt, input logic [15:0] p);
		@(posedge pclk);
		rx_page <= p;
		rx_base_valid <= !nxt;
		rx_next_valid <= nxt;
		@(posedge pclk);
		rx_base_valid <= 1'b0;
		rx_next_valid <= 1'b0;
		rx_page <= ~p;
	endtask
	task automatic set_lvl(input logic a, input logic d);
		@(posedge pclk);
		rx_ack <= a;
		an_complete <= d;
	endtask
	task automatic restart;
		@(posedge pclk);
		an_restart <= 1'b1;
		an_complete <= 1'b0;
		@(posedge pclk);
		an_restart <= 1'b0;
	endtask
endmodule

/* File: verif/lpac_tb_top.sv */
`timescale 1ns/1ps
module lpac_tb_top;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, er;
	logic rx_base_valid, rx_next_valid, rx_ack, an_complete, an_restart;
	logic [7:0] paddr;
	logic [15:0] rx_page;
	logic [31:0] pwdata, prdata, rd;
	int num_errors, checks;
	// page sent, ack level, view expected
	logic [32:0] rows [0:5] = '{{16'h8001, 1'b0, 16'h8001}, {16'h2001, 1'b1, 16'h6001},
		{16'h1C00, 1'b0, 16'h0C00}, {16'h0300, 1'b0, 16'h0300},
		{16'h00E0, 1'b1, 16'h40E0}, {16'h401F, 1'b0, 16'h001F}};
	logic [7:0] regs [0:5] = '{8'h14, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50};
	lpac_top i_lpac_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_page(rx_page), .rx_base_valid(rx_base_valid),
		.rx_next_valid(rx_next_valid), .rx_ack(rx_ack), .an_complete(an_complete),
		.an_restart(an_restart), .irq(irq));
	lpac_partner i_lpac_partner (.pclk(pclk), .rx_page(rx_page), .rx_base_valid(rx_base_valid),
		.rx_next_valid(rx_next_valid), .rx_ack(rx_ack), .an_complete(an_complete),
		.an_restart(an_restart));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer, held until ready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic give_verdict;
		if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#200000;
		num_errors++;
		give_verdict;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 8'h50, 32'h00000001);
		for (int i = 0; i < 6; i++) begin
			i_lpac_partner.set_lvl(rows[i][16], 1'b0);
			chk("irq", 32'h0, {31'h0, irq});
			i_lpac_partner.send(1'b0, rows[i][32:17]);
			apb(1'b0, 8'h14, 32'h0);
			chk("view", {16'h0000, rows[i][15:0]}, rd);
			chk("irq", 32'h1, {31'h0, irq});
			apb(1'b1, 8'h4C, 32'h00000001);
		end
		i_lpac_partner.send(1'b0, 16'h0021);
		apb(1'b0, 8'h48, 32'h0);
		chk("stat", 32'h0000000A, rd);
		apb(1'b1, 8'h14, 32'h0000AFFF);
		chk("werr", 32'h0, {31'h0, er});
		apb(1'b0, 8'h14, 32'h0);
		chk("view", 32'h00000021, rd);
		apb(1'b0, 8'h00, 32'h0);
		chk("uerr", 32'h1, {31'h0, er});
		apb(1'b1, 8'h44, 32'h00000001);
		i_lpac_partner.send(1'b1, 16'h8A05);
		apb(1'b0, 8'h14, 32'h0);
		chk("view", 32'h00000021, rd);
		i_lpac_partner.set_lvl(1'b0, 1'b1);
		apb(1'b0, 8'h14, 32'h0);
		chk("view", 32'h00008A05, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("next", 32'h00008A05, rd);
		i_lpac_partner.restart();
		apb(1'b0, 8'h14, 32'h0);
		chk("view", 32'h00000021, rd);
		// a page offered while the clock enable is low must not land
		clk_en <= 1'b0;
		i_lpac_partner.send(1'b0, 16'h0041);
		clk_en <= 1'b1;
		apb(1'b0, 8'h14, 32'h0);
		chk("freeze", 32'h00000021, rd);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (regs[k]) begin
			apb(1'b0, regs[k], 32'h0);
			chk("reset", 32'h0, rd);
		end
		chk("irq", 32'h0, {31'h0, irq});
		give_verdict;
	end
endmodule
